// >>> sixteen_bit_instruction_execute.v
// Execution engine for byte, status word, string, decimal, shift and input instructions
`timescale 1ns/10ps
`include "sbie_consts.vh"
module sixteen_bit_instruction_execute (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  busAddr,
  input  wire [15:0] busWrData,
  input  wire        busWr,
  input  wire        busRd,
  output reg  [15:0] busRdData,
  output reg  [15:0] memAddr,
  output reg  [15:0] memWrData,
  output reg         memWr,
  output reg         memRd,
  output reg         memByte,
  input  wire [15:0] memRdData,
  output reg  [15:0] ioAddr,
  output reg         ioRd,
  input  wire [15:0] ioRdData,
  input  wire        irqPin,
  output reg         intAck,
  output reg         busy
);
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RUN  = 2'b10;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [15:0] gpr [0:15];
  reg [1:0]  state_q;
  reg [2:0]  step_q;
  reg [15:0] inst0_q;
  reg [15:0] inst1_q;
  reg [31:0] psw_q;
  reg [15:0] sp_q;
  reg [15:0] slLo_q;
  reg [15:0] slHi_q;
  reg [3:0]  gprSel_q;
  reg [7:0]  tmp_q;
  reg        err_q;
  reg        test_q;
  reg        intr_q;
  reg        irqMeta_q;
  reg        irqSync_q;
  reg [15:0] rdMux;
  integer    k;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [7:0]  op    = inst0_q[15:8];
  wire [3:0]  r1    = inst0_q[7:4];
  wire [3:0]  r2    = inst0_q[3:0];
  wire [3:0]  r1p   = r1 + 4'h1;
  wire [15:0] a1    = gpr[r1];
  wire [15:0] a2    = gpr[r2];
  wire [15:0] ea    = ((r2 == 4'h0) ? 16'h0000 : a2) + inst1_q;
  wire [15:0] pc    = psw_q[15:0];
  wire [3:0]  cc    = psw_q[`PSW_CC_HI:`PSW_CC_LO];
  wire        isSh  = (op[7:4] == `OP_SHIFT_HI);
  wire        dbl   = op[3];
  wire [31:0] shIn  = dbl ? {a1, gpr[r1p]} : {16'h0000, a1};
  wire [31:0] shOut;
  wire        shC;
  wire        shV;
  wire [16:0] bcd   = bcdAdd(a1, a2, op == `OP_DSUB);

  // Nibble-wise decimal add, subtract by nines complement plus one
  function [16:0] bcdAdd;
    input [15:0] a;
    input [15:0] b;
    input        sub;
    integer      n;
    reg   [4:0]  s;
    reg   [3:0]  bn;
    reg          c;
    begin
      c = sub;
      bcdAdd = 17'h00000;
      for (n = 0; n < 4; n = n + 1) begin
        bn = sub ? (4'h9 - b[n*4 +: 4]) : b[n*4 +: 4];
        s = {1'b0, a[n*4 +: 4]} + {1'b0, bn} + {4'h0, c};
        if (s > 5'd9) s = s + 5'd6;
        c = s[4];
        bcdAdd[n*4 +: 4] = s[3:0];
      end
      bcdAdd[16] = c;
    end
  endfunction

  shift_rotate_unit uShift (
    .dIn      (shIn),
    .dbl      (dbl),
    .kind     (op[2:0]),
    .count    (ea[4:0]),
    .carryIn  (cc[`CC_C]),
    .dOut     (shOut),
    .carryOut (shC),
    .ovf      (shV)
  );

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always @* begin
    case (busAddr)
      `REG_INSTR0: rdMux = inst0_q;
      `REG_INSTR1: rdMux = inst1_q;
      `REG_STATUS: rdMux = {8'h00, cc, intr_q, test_q, err_q, busy};
      `REG_PSWHI:  rdMux = psw_q[31:16];
      `REG_PSWLO:  rdMux = psw_q[15:0];
      `REG_SP:     rdMux = sp_q;
      `REG_SLLO:   rdMux = slLo_q;
      `REG_SLHI:   rdMux = slHi_q;
      `REG_GPRSEL: rdMux = {12'h000, gprSel_q};
      `REG_GPRDAT: rdMux = gpr[gprSel_q];
      default:     rdMux = 16'h0000;
    endcase
  end

  // Ends the instruction, optionally stepping past it
  task finish;
    input adv;
    begin
      state_q <= S_IDLE;
      busy <= 1'b0;
      if (adv) psw_q[15:0] <= pc + `INSTR_LEN;
    end
  endtask

  // One string element done: shorten length, move addresses on
  task advance;
    input both;
    begin
      gpr[r1] <= a1 - 16'h0001;
      gpr[r1p] <= gpr[r1p] + 16'h0001;
      if (both) gpr[r2] <= a2 + 16'h0001;
      step_q <= 3'd0;
    end
  endtask

  // ----------------------------------------
  // Engine
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < 16; k = k + 1) begin
        gpr[k] <= 16'h0000;
      end
      state_q <= S_IDLE;
      step_q <= 3'd0;
      inst0_q <= 16'h0000;
      inst1_q <= 16'h0000;
      psw_q <= `PSW_RESET;
      sp_q <= `SP_RESET;
      slLo_q <= 16'h0000;
      slHi_q <= 16'h0000;
      gprSel_q <= 4'h0;
      tmp_q <= 8'h00;
      err_q <= 1'b0;
      test_q <= 1'b0;
      intr_q <= 1'b0;
      irqMeta_q <= 1'b0;
      irqSync_q <= 1'b0;
      busRdData <= 16'h0000;
      memAddr <= 16'h0000;
      memWrData <= 16'h0000;
      memWr <= 1'b0;
      memRd <= 1'b0;
      memByte <= 1'b0;
      ioAddr <= 16'h0000;
      ioRd <= 1'b0;
      intAck <= 1'b0;
      busy <= 1'b0;
    end else begin
      memWr <= 1'b0;
      memRd <= 1'b0;
      ioRd <= 1'b0;
      intAck <= 1'b0;
      irqMeta_q <= irqPin;
      irqSync_q <= irqMeta_q;
      busRdData <= busRd ? rdMux : 16'h0000;
      case (state_q)
        S_IDLE: begin
          if (busWr) begin
            case (busAddr)
              `REG_INSTR0: inst0_q <= busWrData;
              `REG_INSTR1: inst1_q <= busWrData;
              `REG_PSWHI:  psw_q[31:16] <= busWrData;
              `REG_PSWLO:  psw_q[15:0] <= busWrData;
              `REG_SP:     sp_q <= busWrData;
              `REG_SLLO:   slLo_q <= busWrData;
              `REG_SLHI:   slHi_q <= busWrData;
              `REG_GPRSEL: gprSel_q <= busWrData[3:0];
              `REG_GPRDAT: gpr[gprSel_q] <= busWrData;
              `REG_CTRL: begin
                if (busWrData[`CTRL_START]) begin
                  state_q <= S_RUN;
                  busy <= 1'b1;
                  step_q <= 3'd0;
                  err_q <= 1'b0;
                  intr_q <= 1'b0;
                end
              end
              default: ;
            endcase
          end
        end
        S_RUN: begin
          step_q <= step_q + 3'd1;
          if (isSh) begin
            if (dbl && r1[0]) begin
              err_q <= 1'b1;
              finish(1'b0);
            end else begin
              if (dbl) begin
                gpr[r1] <= shOut[31:16];
                gpr[r1p] <= shOut[15:0];
              end else begin
                gpr[r1] <= shOut[15:0];
              end
              psw_q[`PSW_CC_LO+`CC_C] <= shC;
              psw_q[`PSW_CC_LO+`CC_Z] <= (shOut == 32'h00000000);
              if (shV) psw_q[`PSW_CC_LO+`CC_V] <= 1'b1;
              finish(1'b1);
            end
          end else begin
            case (op)
              `OP_XB: begin
                gpr[r1] <= {a1[15:8], a2[7:0]};
                gpr[r2] <= {a2[15:8], a1[7:0]};
                finish(1'b1);
              end
              `OP_SWB: begin
                gpr[r1] <= {a2[7:0], a2[15:8]};
                finish(1'b1);
              end
              `OP_CLB: begin
                psw_q[`PSW_CC_LO+`CC_Z] <= (a1[7:0] == a2[7:0]);
                psw_q[`PSW_CC_LO+`CC_C] <= (a1[7:0] < a2[7:0]);
                psw_q[`PSW_CC_LO+`CC_N] <= (a1[7:0] < a2[7:0]);
                finish(1'b1);
              end
              `OP_NB, `OP_OB, `OP_XOB: begin
                case (op)
                  `OP_NB:  gpr[r1] <= {8'h00, a1[7:0] & a2[7:0]};
                  `OP_OB:  gpr[r1] <= {8'h00, a1[7:0] | a2[7:0]};
                  default: gpr[r1] <= {8'h00, a1[7:0] ^ a2[7:0]};
                endcase
                finish(1'b1);
              end
              `OP_LPSW: begin
                case (step_q)
                  3'd0: begin
                    memAddr <= ea;
                    memByte <= 1'b0;
                    memRd <= 1'b1;
                  end
                  3'd2: begin
                    psw_q[31:16] <= memRdData;
                    memAddr <= memAddr + 16'h0002;
                    memRd <= 1'b1;
                  end
                  3'd4: begin
                    psw_q[15:0] <= memRdData;
                    finish(1'b0);
                  end
                  default: ;
                endcase
              end
              `OP_SPSW: begin
                memByte <= 1'b0;
                memWr <= 1'b1;
                if (step_q == 3'd0) begin
                  memAddr <= ea;
                  memWrData <= psw_q[31:16];
                end else begin
                  memAddr <= memAddr + 16'h0002;
                  memWrData <= pc;
                  finish(1'b1);
                end
              end
              `OP_FLG: begin
                case (r1[1:0])
                  2'd0: psw_q[`PSW_CC_HI:`PSW_CC_LO] <= cc | r2;
                  2'd1: psw_q[`PSW_CC_HI:`PSW_CC_LO] <= cc & ~r2;
                  2'd2: psw_q[`PSW_CC_HI:`PSW_CC_LO] <= cc ^ r2;
                  default: test_q <= |(cc & r2);
                endcase
                finish(1'b1);
              end
              `OP_CALL: begin
                sp_q <= sp_q - 16'h0002;
                memAddr <= sp_q - 16'h0002;
                memByte <= 1'b0;
                memWrData <= pc;
                memWr <= 1'b1;
                psw_q[15:0] <= ea;
                finish(1'b0);
              end
              `OP_LSTK: begin
                if (step_q == 3'd0) begin
                  memAddr <= ea;
                  memByte <= 1'b0;
                  memRd <= 1'b1;
                end else if (step_q == 3'd2) begin
                  case (r1[1:0])
                    2'd0:    sp_q <= memRdData;
                    2'd1:    slLo_q <= memRdData;
                    default: slHi_q <= memRdData;
                  endcase
                  finish(1'b1);
                end
              end
              `OP_STSTK: begin
                memAddr <= ea;
                memByte <= 1'b0;
                memWr <= 1'b1;
                case (r1[1:0])
                  2'd0:    memWrData <= sp_q;
                  2'd1:    memWrData <= slLo_q;
                  default: memWrData <= slHi_q;
                endcase
                finish(1'b1);
              end
              `OP_TR, `OP_TRT, `OP_MVL, `OP_CLL: begin
                case (step_q)
                  3'd0: begin
                    if (a1 == 16'h0000) begin
                      finish(1'b1);
                    end else if (irqSync_q && op != `OP_CLL && op != `OP_TRT) begin
                      intAck <= 1'b1;
                      intr_q <= 1'b1;
                      finish(1'b0);
                    end else begin
                      memAddr <= gpr[r1p];
                      memByte <= 1'b1;
                      memRd <= 1'b1;
                    end
                  end
                  3'd2: begin
                    tmp_q <= memRdData[7:0];
                    if (op == `OP_MVL) begin
                      memAddr <= a2;
                      memWrData <= {8'h00, memRdData[7:0]};
                      memWr <= 1'b1;
                      advance(1'b1);
                    end else begin
                      memAddr <= (op == `OP_CLL) ? a2 : a2 + {8'h00, memRdData[7:0]};
                      memRd <= 1'b1;
                    end
                  end
                  3'd4: begin
                    if (op == `OP_TR) begin
                      memAddr <= gpr[r1p];
                      memWrData <= {8'h00, memRdData[7:0]};
                      memWr <= 1'b1;
                      advance(1'b0);
                    end else if (op == `OP_TRT) begin
                      if (memRdData[7:0] != 8'h00) begin
                        gpr[1] <= memAddr;
                        finish(1'b1);
                      end else begin
                        advance(1'b0);
                      end
                    end else begin
                      if (memRdData[7:0] != tmp_q) begin
                        psw_q[`PSW_CC_LO+`CC_Z] <= 1'b0;
                        psw_q[`PSW_CC_LO+`CC_C] <= (tmp_q < memRdData[7:0]);
                        finish(1'b1);
                      end else begin
                        psw_q[`PSW_CC_LO+`CC_Z] <= 1'b1;
                        advance(1'b1);
                      end
                    end
                  end
                  default: ;
                endcase
              end
              `OP_EXEC: begin
                case (step_q)
                  3'd0: begin
                    memAddr <= ea;
                    memByte <= 1'b0;
                    memRd <= 1'b1;
                  end
                  3'd2: begin
                    inst0_q <= memRdData | a1;
                    memAddr <= memAddr + 16'h0002;
                    memRd <= 1'b1;
                  end
                  3'd4: begin
                    inst1_q <= memRdData;
                    step_q <= 3'd0;
                  end
                  default: ;
                endcase
              end
              `OP_DADD, `OP_DSUB: begin
                gpr[r1] <= bcd[15:0];
                psw_q[`PSW_CC_LO+`CC_C] <= (op == `OP_DSUB) ? ~bcd[16] : bcd[16];
                psw_q[`PSW_CC_LO+`CC_Z] <= (bcd[15:0] == 16'h0000);
                finish(1'b1);
              end
              `OP_DXI: begin
                if (step_q == 3'd0) begin
                  gpr[r1] <= a1 - 16'h0001;
                end else begin
                  gpr[r2] <= a2 - 16'h0001;
                  finish(1'b1);
                end
              end
              `OP_INW, `OP_INB: begin
                if (step_q == 3'd0) begin
                  ioAddr <= ea;
                  ioRd <= 1'b1;
                end else if (step_q == 3'd2) begin
                  if (op == `OP_INW) gpr[r1] <= ioRdData;
                  else gpr[r1] <= {a1[15:8], ioRdData[7:0]};
                  finish(1'b1);
                end
              end
              default: begin
                err_q <= 1'b1;
                finish(1'b0);
              end
            endcase
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> sbie_consts.vh
// Constants for the sixteen-bit instruction execute block
//
// Functional notes
// - Exchange byte swaps only low bytes
// - Byte swap loads swapped second operand
// - Byte compare sets condition code only
// - Byte logic writes low byte, clears high
// - Status word loads/stores whole 32 bits
// - Flag ops set/clear/complement/test masked bits
// - Call pushes status bits 0:15, then jumps
// - Stack pointer and limits move to/from memory
// - Translate replaces bytes via table until zero
// - Translate interruptible, counter left on it
// - Translate-test halts on nonzero, address in R1
// - Move long copies bytes, increments, interruptible
// - Compare long stops at zero or mismatch
// - Execute ORs fetched upper word with R1
// - Decimal add/subtract works nibble by nibble
// - Decrement indexes subtracts one from each
// - Arithmetic right shift fills with sign
// - Rotates single register or register pair
// - Arithmetic left keeps sign, flags overflow
// - Logical right fills zeros, out through carry
// - Logical left fills zeros, pair must be even
// - Input word loads 16 bits, byte low 8
`ifndef SBIE_CONSTS_VH
`define SBIE_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_INSTR0  4'h0
`define REG_INSTR1  4'h1
`define REG_CTRL    4'h2
`define REG_STATUS  4'h3
`define REG_PSWHI   4'h4
`define REG_PSWLO   4'h5
`define REG_SP      4'h6
`define REG_SLLO    4'h7
`define REG_SLHI    4'h8
`define REG_GPRSEL  4'h9
`define REG_GPRDAT  4'hA

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_START  0
`define PSW_CC_HI   19
`define PSW_CC_LO   16
`define CC_C        3
`define CC_V        2
`define CC_Z        1
`define CC_N        0
`define PSW_RESET   32'h00000000
`define SP_RESET    16'h0000
`define INSTR_LEN   16'h0004

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_XB       8'h01
`define OP_SWB      8'h02
`define OP_CLB      8'h03
`define OP_NB       8'h04
`define OP_OB       8'h05
`define OP_XOB      8'h06
`define OP_LPSW     8'h07
`define OP_SPSW     8'h08
`define OP_FLG      8'h09
`define OP_CALL     8'h0A
`define OP_LSTK     8'h0B
`define OP_STSTK    8'h0C
`define OP_TR       8'h0D
`define OP_TRT      8'h0E
`define OP_MVL      8'h0F
`define OP_CLL      8'h10
`define OP_EXEC     8'h11
`define OP_DADD     8'h12
`define OP_DSUB     8'h13
`define OP_DXI      8'h14
`define OP_INW      8'h15
`define OP_INB      8'h16
`define OP_SHIFT_HI 4'h2

// ----------------------------------------
// Shift kinds
// ----------------------------------------
`define SH_SRA      3'h0
`define SH_SRL      3'h1
`define SH_SLA      3'h2
`define SH_SLL      3'h3
`define SH_RR       3'h4
`define SH_RL       3'h5

`endif

// >>> shift_rotate_unit.v
// Shift and rotate datapath for single and double operands
`timescale 1ns/10ps
`include "sbie_consts.vh"
module shift_rotate_unit (
  input  wire [31:0] dIn,
  input  wire        dbl,
  input  wire [2:0]  kind,
  input  wire [4:0]  count,
  input  wire        carryIn,
  output reg  [31:0] dOut,
  output reg         carryOut,
  output reg         ovf
);
  integer i;
  integer sp;
  reg     sgn;
  reg     hi;
  always @* begin
    sp = dbl ? 31 : 15;
    dOut = dbl ? dIn : {16'h0000, dIn[15:0]};
    carryOut = carryIn;
    ovf = 1'b0;
    hi = 1'b0;
    sgn = dOut[sp];
    for (i = 0; i < 31; i = i + 1) begin
      if (i < count) begin
        hi = dOut[sp];
        case (kind)
          `SH_SRA: begin
            carryOut = dOut[0];
            dOut = dOut >> 1;
            dOut[sp] = sgn;
          end
          `SH_SRL: begin
            carryOut = dOut[0];
            dOut = dOut >> 1;
          end
          `SH_SLA: begin
            if (dOut[sp-1] != sgn) ovf = 1'b1;
            dOut = dOut << 1;
            dOut[sp] = sgn;
          end
          `SH_SLL: begin
            carryOut = hi;
            dOut = dOut << 1;
          end
          `SH_RR: begin
            hi = dOut[0];
            dOut = dOut >> 1;
            dOut[sp] = hi;
          end
          default: begin
            dOut = dOut << 1;
            dOut[0] = hi;
          end
        endcase
        if (!dbl) dOut[31:16] = 16'h0000;
      end
    end
  end
endmodule

// >>> mem_io_model.sv
// Memory and device model facing the execute block
`timescale 1ns/10ps
module mem_io_model (
  input  wire        clk,
  input  wire [15:0] memAddr,
  input  wire [15:0] memWrData,
  input  wire        memWr,
  input  wire        memRd,
  input  wire        memByte,
  output wire [15:0] memRdData,
  input  wire [15:0] ioAddr,
  input  wire        ioRd,
  output wire [15:0] ioRdData
);
  reg [7:0]  mem [0:255];
  reg [15:0] mq;
  reg [15:0] iq;
  reg        mv;
  reg        iv;
  initial begin
    mv = 1'b0;
    iv = 1'b0;
    mq = 16'h0000;
    iq = 16'h0000;
  end
  // Data stand one cycle, then the inverse of the last value
  assign memRdData = mv ? mq : ~mq;
  assign ioRdData  = iv ? iq : ~iq;
  always @(posedge clk) begin
    mv <= memRd;
    iv <= ioRd;
    if (memRd)
      mq <= memByte ? {8'h00, mem[memAddr[7:0]]} : {mem[memAddr[7:0]], mem[memAddr[7:0] + 8'h01]};
    if (ioRd)
      iq <= ioAddr ^ 16'h5A3C;
    if (memWr)
      mem[memAddr[7:0]] <= memByte ? memWrData[7:0] : memWrData[15:8];
    if (memWr && !memByte)
      mem[memAddr[7:0] + 8'h01] <= memWrData[7:0];
  end
endmodule

// >>> sbie_chk.sv
// Port timing checker for the execute block
`timescale 1ns/10ps
module sbie_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [15:0] busRdData,
  input wire logic        memWr,
  input wire logic        memRd,
  input wire logic        ioRd,
  input wire logic        intAck,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rdIdle; !$past(busRd) |-> busRdData == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_rdGap; memRd |=> !memRd; endproperty
  a_rdGap: assert property (p_rdGap) else $error("memory read too long");
  property p_rdBusy; memRd |=> busy; endproperty
  a_rdBusy: assert property (p_rdBusy) else $error("read while idle");
  property p_excl; !(memRd && memWr); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_ioPulse; ioRd |=> !ioRd && busy; endproperty
  a_ioPulse: assert property (p_ioPulse) else $error("device read bad");
  property p_ackPulse; intAck |=> !intAck; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_idle; !busy && !$past(busy) |-> !memRd && !memWr && !ioRd; endproperty
  a_idle: assert property (p_idle) else $error("access while idle");
  property p_start; $rose(busy) |-> $past(busWr); endproperty
  a_start: assert property (p_start) else $error("busy without start");
endmodule
bind sixteen_bit_instruction_execute sbie_chk sbie_chk_inst (.clk(clk), .reset_n(reset_n),
  .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .memWr(memWr), .memRd(memRd),
  .ioRd(ioRd), .intAck(intAck), .busy(busy));

// >>> tb.sv
// Self-checking bench for the execute block
`timescale 1ns/10ps
`include "sbie_consts.vh"
module tb;
  reg         clk, reset_n, busWr, busRd, irqPin, sd;
  reg  [3:0]  busAddr;
  reg  [15:0] busWrData, a, b, x, y;
  reg  [31:0] e;
  reg  [7:0]  op;
  reg  [4:0]  c;
  reg  [2:0]  sk;
  integer     n_fail, tests_run, seed, cyc, k, n;
  wire [15:0] busRdData, memAddr, memWrData, memRdData, ioAddr, ioRdData;
  wire        memWr, memRd, memByte, ioRd, intAck, busy;
  sixteen_bit_instruction_execute sixteen_bit_instruction_execute_inst (
    .clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
    .busRd(busRd), .busRdData(busRdData), .memAddr(memAddr), .memWrData(memWrData),
    .memWr(memWr), .memRd(memRd), .memByte(memByte), .memRdData(memRdData),
    .ioAddr(ioAddr), .ioRd(ioRd), .ioRdData(ioRdData), .irqPin(irqPin), .intAck(intAck),
    .busy(busy));
  mem_io_model mem_io_model_inst (
    .clk(clk), .memAddr(memAddr), .memWrData(memWrData), .memWr(memWr), .memRd(memRd),
    .memByte(memByte), .memRdData(memRdData), .ioAddr(ioAddr), .ioRd(ioRd),
    .ioRdData(ioRdData));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [15:0] ex, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, ex, got);
      end
    end
  endtask
  task wr(input [3:0] ad, input [15:0] d);
    begin
      @(posedge clk);
      busAddr <= ad;
      busWrData <= d;
      busWr <= 1'b1;
      @(posedge clk);
      busWr <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad, output [15:0] d);
    begin
      @(posedge clk);
      busAddr <= ad;
      busRd <= 1'b1;
      @(posedge clk);
      busRd <= 1'b0;
      #1 d = busRdData;
    end
  endtask
  task setr(input [3:0] r, input [15:0] v);
    begin
      wr(4'h9, {12'h000, r});
      wr(4'hA, v);
    end
  endtask
  task getr(input [3:0] r, output [15:0] v);
    begin
      wr(4'h9, {12'h000, r});
      rd(4'hA, v);
    end
  endtask
  // Start one instruction and wait for it to finish
  task run(input [7:0] o, input [3:0] r1, input [3:0] r2, input [15:0] d);
    begin
      wr(4'h0, {o, r1, r2});
      wr(4'h1, d);
      wr(4'h2, 16'h0001);
      #1;
      for (n = 0; busy !== 1'b0 && n < 3000; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      chk(16'h0000, {15'h0000, busy});
    end
  endtask
  function [31:0] rexp(input [7:0] o, input [15:0] p, input [15:0] q);
    case (o)
      `OP_XB:  rexp = {p[15:8], q[7:0], q[15:8], p[7:0]};
      `OP_SWB: rexp = {q[7:0], q[15:8], q};
      `OP_NB:  rexp = {8'h00, p[7:0] & q[7:0], q};
      `OP_OB:  rexp = {8'h00, p[7:0] | q[7:0], q};
      `OP_XOB: rexp = {8'h00, p[7:0] ^ q[7:0], q};
      `OP_DXI: rexp = {p - 16'h0001, q - 16'h0001};
      default: rexp = {p, q};
    endcase
  endfunction
  function [31:0] shx(input [2:0] t, input d, input [31:0] v, input [4:0] m);
    reg [63:0] w;
    begin
      w = d ? {v, v} : {32'h00000000, v[15:0], v[15:0]};
      case (t)
        `SH_SRA: shx = d ? $signed(v) >>> m : $signed(v[15:0]) >>> m;
        `SH_SRL: shx = d ? v >> m : v[15:0] >> m;
        `SH_SLA: shx = d ? {v[31], v[30:0] << m} : {v[15], v[14:0] << m};
        `SH_SLL: shx = v << m;
        `SH_RR:  shx = w >> m;
        default: begin
          w = w << m;
          shx = d ? w[63:32] : {16'h0000, w[31:16]};
        end
      endcase
      if (!d)
        shx[31:16] = 16'h0000;
    end
  endfunction
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    busWr = 1'b0;
    busRd = 1'b0;
    irqPin = 1'b0;
    busAddr = 4'h0;
    busWrData = 16'h0000;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    seed = 23563;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h6, x);
    chk(16'h0000, x);
    for (k = 0; k < 21; k = k + 1) begin
      op = (k % 7 == 6) ? `OP_DXI : `OP_XB + k % 7;
      a = $random(seed);
      b = $random(seed);
      if (k > 13) begin
        a = 16'h0000;
        b = 16'hFFFF;
      end
      setr(4'h2, a);
      setr(4'h3, b);
      run(op, 4'h2, 4'h3, 16'h0000);
      e = rexp(op, a, b);
      getr(4'h2, x);
      chk(e[31:16], x);
      getr(4'h3, x);
      chk(e[15:0], x);
    end
    setr(4'h5, a);
    run(`OP_DXI, 4'h5, 4'h5, 16'h0000);
    getr(4'h5, x);
    chk(a - 16'h0002, x);
    for (k = 0; k < 36; k = k + 1) begin
      sk = k % 6;
      sd = (k / 6) % 2;
      a = $random(seed);
      b = $random(seed);
      c = (k < 12) ? {sd, 4'hF} : {sd & a[0], b[3:0]};
      setr(4'h2, a);
      setr(4'h3, b);
      run({`OP_SHIFT_HI, sd, sk}, 4'h2, 4'h0, {11'h000, c});
      e = shx(sk, sd, sd ? {a, b} : {16'h0000, a}, c);
      getr(4'h2, x);
      chk(sd ? e[31:16] : e[15:0], x);
      getr(4'h3, x);
      chk(sd ? e[15:0] : b, x);
    end
    setr(4'h3, b);
    run({`OP_SHIFT_HI, 1'b1, `SH_SLL}, 4'h3, 4'h0, 16'h0001);
    getr(4'h3, x);
    chk(b, x);
    for (k = 0; k < 4; k = k + 1) begin
      a = $random(seed);
      y = $random(seed);
      setr(4'h2, a);
      run(k[0] ? `OP_INB : `OP_INW, 4'h2, 4'h0, y);
      getr(4'h2, x);
      chk(k[0] ? {a[15:8], y[7:0] ^ 8'h3C} : y ^ 16'h5A3C, x);
    end
    e = $random(seed);
    mem_io_model_inst.mem[8'h40] = e[31:24];
    mem_io_model_inst.mem[8'h41] = e[23:16];
    mem_io_model_inst.mem[8'h42] = e[15:8];
    mem_io_model_inst.mem[8'h43] = e[7:0];
    run(`OP_LPSW, 4'h0, 4'h0, 16'h0040);
    rd(4'h4, x);
    chk(e[31:16], x);
    rd(4'h5, x);
    chk(e[15:0], x);
    y = e[31:16];
    for (k = 0; k < 4; k = k + 1) begin
      b = $random(seed);
      run(`OP_FLG, k[3:0], b[3:0], 16'h0000);
      case (k)
        0: y[3:0] = y[3:0] | b[3:0];
        1: y[3:0] = y[3:0] & ~b[3:0];
        2: y[3:0] = y[3:0] ^ b[3:0];
        default: a = {15'h0000, |(y[3:0] & b[3:0])};
      endcase
      rd(4'h4, x);
      chk(y, x);
    end
    rd(4'h3, x);
    chk(a, {15'h0000, x[2]});
    setr(4'h2, 16'h0958);
    setr(4'h3, 16'h0467);
    run(`OP_DADD, 4'h2, 4'h3, 16'h0000);
    getr(4'h2, x);
    chk(16'h1425, x);
    run(`OP_DSUB, 4'h2, 4'h3, 16'h0000);
    getr(4'h2, x);
    chk(16'h0958, x);
    irqPin <= 1'b1;
    setr(4'h4, 16'h0005);
    rd(4'h5, y);
    run(`OP_TR, 4'h4, 4'h6, 16'h0000);
    irqPin <= 1'b0;
    rd(4'h5, x);
    chk(y, x);
    rd(4'h3, x);
    chk(16'h0001, {15'h0000, x[3]});
    for (k = 0; k < 3; k = k + 1) begin
      run(`OP_STSTK, k[3:0], 4'h0, 16'h0050);
      run(`OP_LSTK, k[3:0], 4'h0, 16'h0040);
      rd(4'h6 + k[3:0], x);
      chk(e[31:16], x);
      chk(16'h0000, {mem_io_model_inst.mem[8'h50], mem_io_model_inst.mem[8'h51]});
    end
    rd(4'h5, y);
    run(`OP_CALL, 4'h0, 4'h0, 16'h0080);
    rd(4'h5, x);
    chk(16'h0080, x);
    b = e[31:16] - 16'h0002;
    chk(y, {mem_io_model_inst.mem[b[7:0]], mem_io_model_inst.mem[b[7:0] + 8'h01]});
    print_verdict;
  end
endmodule
